/* File: shared/rbic_pkg.sv */
// constants shared by the reset, boot-mode and interrupt pin control block
package rbic_pkg;
  // ----------------------------------------------------------------
  // bus geometry, register map, fields, sizes and reset values
  // ----------------------------------------------------------------
  localparam int          RBIC_AW         = 8;
  localparam int          RBIC_DW         = 32;
  localparam logic [1:0]  RBIC_RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RBIC_RESP_SLVERR = 2'h2;
  localparam logic [7:0]  ADDR_PUDR       = 8'h00;
  localparam logic [7:0]  ADDR_PUR        = 8'h04;
  localparam logic [7:0]  ADDR_FSEL       = 8'h08;
  localparam logic [7:0]  ADDR_GDIR       = 8'h0c;
  localparam logic [7:0]  ADDR_GOUT       = 8'h10;
  localparam logic [7:0]  ADDR_GIN        = 8'h14;
  localparam logic [7:0]  ADDR_ICFG       = 8'h18;
  localparam logic [7:0]  ADDR_ISTAT      = 8'h1c;
  localparam logic [7:0]  ADDR_OMR        = 8'h20;
  localparam int          PUD_RESET_BIT   = 0;
  localparam int          PUD_IRQ_BIT     = 1;
  localparam int          PUD_BOOT_STRAP_PULLUP_DISABLE_BIT   = 2;
  localparam int          PUD_EMI_BIT     = 3;
  localparam int          ISTAT_LVL_POS   = 2;
  localparam int          OMR_MA_BIT      = 0;
  localparam int          OMR_MB_BIT      = 1;
  localparam int          OMR_A20_BIT     = 2;
  localparam int          OMR_RDY_BIT     = 3;
  localparam int          NUM_TPINS       = 4;
  localparam int          NUM_IRQ         = 2;
  localparam int          RESET_RELEASE_CYCLES = 32;
  localparam logic [3:0]  PUDR_RST        = 4'h0;
  localparam logic [3:0]  PUR_RST         = 4'hf;
  localparam logic [3:0]  FSEL_RST        = 4'h0;
  localparam logic [3:0]  GDIR_RST        = 4'h0;
  localparam logic [3:0]  GOUT_RST        = 4'h0;
  localparam logic [1:0]  ICFG_RST        = 2'h0;
endpackage : rbic_pkg

/* File: shared/rbic_reg_if.sv */
// register access carrier between the bus slave and the register file
`timescale 1ns/1ps
interface rbic_reg_if;
  import rbic_pkg::*;
  logic                wr_en;
  logic [RBIC_AW-1:0]  wr_addr;
  logic [RBIC_DW-1:0]  wr_data;
  logic [3:0]          wr_strb;
  logic                wr_err;
  logic                rd_en;
  logic [RBIC_AW-1:0]  rd_addr;
  logic [RBIC_DW-1:0]  rd_data;
  logic                rd_err;
  modport bus_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                    input  wr_err, rd_data, rd_err);
  modport reg_side (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                    output wr_err, rd_data, rd_err);
endinterface : rbic_reg_if

/* File: rtl/rbic_irq_cond.sv */
// one external interrupt request channel: synchroniser, edge or level sensing
`timescale 1ns/1ps
module rbic_irq_cond
  import rbic_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic req_n,
  input  wire logic edge_mode,
  input  wire logic clr,
  output logic      req,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pend;
    logic req;
  } rbic_irq_st_t;
  rbic_irq_st_t st_r, st_nxt;
  logic         fall;
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = req_n;
    st_nxt.s2   = st_r.s1;
    st_nxt.prev = st_r.s2;
    fall        = st_r.prev & ~st_r.s2;
    // a falling edge in the clear cycle is kept
    st_nxt.pend = (st_r.pend & ~clr) | fall;
    st_nxt.req  = edge_mode ? st_nxt.pend : ~st_r.s2;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, pend: 1'b0, req: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign req   = st_r.req;
  assign level = ~st_r.s2;
endmodule : rbic_irq_cond

/* File: rtl/rbic_axil_slave.sv */
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/1ps
module rbic_axil_slave
  import rbic_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [RBIC_AW-1:0] awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [RBIC_DW-1:0] wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [RBIC_AW-1:0] araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [RBIC_DW-1:0]      rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  rbic_reg_if.bus_side            rif
);
  typedef struct packed {
    logic               aw_full;
    logic [RBIC_AW-1:0] aw_addr;
    logic               w_full;
    logic [RBIC_DW-1:0] w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [RBIC_DW-1:0] rdata;
    logic [1:0]         rresp;
  } rbic_axi_st_t;
  rbic_axi_st_t st_r, st_nxt;
  logic         do_wr;
  always_comb begin
    st_nxt = st_r;
    do_wr  = st_r.aw_full & st_r.w_full & ~st_r.bvalid;
    if (awvalid & ~st_r.aw_full) begin
      st_nxt.aw_full = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid & ~st_r.w_full) begin
      st_nxt.w_full = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (do_wr) begin
      st_nxt.aw_full = 1'b0;
      st_nxt.w_full  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = rif.wr_err ? RBIC_RESP_SLVERR : RBIC_RESP_OKAY;
    end else if (st_r.bvalid & bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (arvalid & ~st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rif.rd_data;
      st_nxt.rresp  = rif.rd_err ? RBIC_RESP_SLVERR : RBIC_RESP_OKAY;
    end else if (st_r.rvalid & rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign awready     = ~st_r.aw_full;
  assign wready      = ~st_r.w_full;
  assign bvalid      = st_r.bvalid;
  assign bresp       = st_r.bresp;
  assign arready     = ~st_r.rvalid;
  assign rvalid      = st_r.rvalid;
  assign rdata       = st_r.rdata;
  assign rresp       = st_r.rresp;
  assign rif.wr_en   = do_wr;
  assign rif.wr_addr = st_r.aw_addr;
  assign rif.wr_data = st_r.w_data;
  assign rif.wr_strb = st_r.w_strb;
  assign rif.rd_en   = arvalid & ~st_r.rvalid;
  assign rif.rd_addr = araddr;
endmodule : rbic_axil_slave

/* File: rtl/rbic_ctrl.sv */
// reset sequencing, boot strap capture, interrupt pin and timer pin control
//
// Behaviour
// - timer d pins leave reset as timer pins; gpio per pin later
// - timer pin pull-up off while its port e pull-up bit is clear
// - in stop or wait irq pins are accepted without a clock
// - outside stop and wait irq pins are synchronised first
// - each irq is level sensitive or falling edge triggered
// - irq pin pull-ups off when their disable bit is set
// - reset pin low holds the device in reset
// - reset pin release latches the boot strap into the mode
// - internal reset drops synchronously a fixed count after release
// - power-on reset asserts internal reset without the reset pin
// - reset pin pull-up off when its disable bit is set
// - reset status output follows internal reset
// - external boot honoured only with unsecured flash
// - width strap high adds four address lines, twenty in all
// - width also depends on boot level and flash security
// - boot strap pull-up off when its disable bit is set
// - width strap pull-up off when its disable bit is set
// - secured flash with external boot request gives internal boot, mode zero
// - unsecured external boot takes width from strap; internal boot sixteen lines
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rbic_ctrl
  import rbic_pkg::*;
#(
  parameter int RELEASE_CYCLES = RESET_RELEASE_CYCLES
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // axi4-lite register port
  input  wire logic [RBIC_AW-1:0]   S_AXI_AWADDR,
  input  wire logic [2:0]           S_AXI_AWPROT,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [RBIC_DW-1:0]   S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [RBIC_AW-1:0]   S_AXI_ARADDR,
  input  wire logic [2:0]           S_AXI_ARPROT,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [RBIC_DW-1:0]        S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  // reset and boot straps
  input  wire logic                 EXT_RESET_PIN_N,
  input  wire logic                 EXTERNAL_BOOT_STRAP,
  input  wire logic                 EXT_MEM_ADDR_WIDTH_STRAP,
  input  wire logic                 FLASH_SECURED,
  output logic                      CHIP_RESET,
  output logic                      RESET_STATUS_OUT,
  output logic                      BOOT_MODE_BIT_A,
  output logic                      FLASH_SECURED_MODE_BIT,
  output logic                      EXTRA_ADDR_LINES_EN,
  // pull-up controls, high = pull-up on
  output logic                      RESET_PIN_PULLUP_EN,
  output logic                      IRQ_PINS_PULLUP_EN,
  output logic                      BOOT_STRAP_PULLUP_EN,
  output logic                      WIDTH_STRAP_PULLUP_EN,
  output logic [NUM_TPINS-1:0]      TIMER_PIN_PULLUP_EN,
  // external interrupt requests
  input  wire logic                 LOW_POWER_MODE,
  input  wire logic                 EXT_INTERRUPT_REQ_A_N,
  input  wire logic                 EXT_INTERRUPT_REQ_B_N,
  output logic                      WAKE_REQUEST,
  output logic                      IRQ_SERVICE_A,
  output logic                      IRQ_SERVICE_B,
  // timer d channel pins, shared with port e gpio
  input  wire logic [NUM_TPINS-1:0] TIMER_D_CHANNEL_PIN_I,
  output logic [NUM_TPINS-1:0]      TIMER_D_CHANNEL_PIN_O,
  output logic [NUM_TPINS-1:0]      TIMER_D_CHANNEL_PIN_OE,
  input  wire logic [NUM_TPINS-1:0] TIMER_OUT,
  input  wire logic [NUM_TPINS-1:0] TIMER_OUT_EN,
  output logic [NUM_TPINS-1:0]      TIMER_IN
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int CW = $clog2(RELEASE_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(RELEASE_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0]        cnt;
    logic                 chip_rst;
    logic                 captured;
    logic                 ma;
    logic                 mb;
    logic                 a20;
    logic [3:0]           pudr;
    logic [NUM_TPINS-1:0] pur;
    logic [NUM_TPINS-1:0] fsel;
    logic [NUM_TPINS-1:0] gdir;
    logic [NUM_TPINS-1:0] gout;
    logic [NUM_TPINS-1:0] gin;
    logic [NUM_IRQ-1:0]   icfg;
    logic [NUM_TPINS-1:0] pin_o;
    logic [NUM_TPINS-1:0] pin_oe;
    logic [NUM_TPINS-1:0] tin;
  } rbic_st_t;

  rbic_st_t st_r, st_nxt;

  rbic_reg_if          rif ();
  logic                pin_low;
  logic [NUM_IRQ-1:0]  irq_n;
  logic [NUM_IRQ-1:0]  irq_req;
  logic [NUM_IRQ-1:0]  irq_lvl;
  logic [NUM_IRQ-1:0]  irq_clr;
  logic                wr_lo;

  function automatic logic addr_known(input logic [RBIC_AW-1:0] a);
    case (a)
      ADDR_PUDR, ADDR_PUR, ADDR_FSEL, ADDR_GDIR, ADDR_GOUT,
      ADDR_GIN, ADDR_ICFG, ADDR_ISTAT, ADDR_OMR: addr_known = 1'b1;
      default:                                   addr_known = 1'b0;
    endcase
  endfunction : addr_known

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  rbic_axil_slave u_bus (
    .clk     (CLOCK),
    .rst     (RST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .rif     (rif.bus_side)
  );

  // ----------------------------------------------------------------
  // interrupt request channels
  // ----------------------------------------------------------------
  assign irq_n   = {EXT_INTERRUPT_REQ_B_N, EXT_INTERRUPT_REQ_A_N};
  // pending bits: write one to clear, also cleared while the reset pin is low
  assign wr_lo   = rif.wr_en & rif.wr_strb[0];
  assign irq_clr = (wr_lo && rif.wr_addr == ADDR_ISTAT) ? rif.wr_data[NUM_IRQ-1:0] : '0;

  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
    rbic_irq_cond u_irq (
      .clk       (CLOCK),
      .rst       (RST),
      .req_n     (irq_n[i]),
      .edge_mode (st_r.icfg[i]),
      .clr       (irq_clr[i] | pin_low),
      .req       (irq_req[i]),
      .level     (irq_lvl[i])
    );
  end

  // gated clocks may be stopped here, so wake is a pure combinational path
  assign WAKE_REQUEST  = LOW_POWER_MODE & ~(&irq_n);
  assign IRQ_SERVICE_A = irq_req[0];
  assign IRQ_SERVICE_B = irq_req[1];

  // ----------------------------------------------------------------
  // reset sequencing, strap capture, registers
  // ----------------------------------------------------------------
  assign pin_low = ~EXT_RESET_PIN_N;

  always_comb begin
    st_nxt = st_r;
    // reset release counter
    if (pin_low) begin
      st_nxt.chip_rst = 1'b1;
      st_nxt.cnt      = '0;
      st_nxt.captured = 1'b0;
    end else if (st_r.chip_rst) begin
      if (!st_r.captured) begin
        st_nxt.captured = 1'b1;
        st_nxt.mb       = ~FLASH_SECURED;
        // secured flash forces both mode bits low
        st_nxt.ma       = EXTERNAL_BOOT_STRAP & ~FLASH_SECURED;
        // internal boot keeps sixteen lines
        st_nxt.a20      = EXTERNAL_BOOT_STRAP & ~FLASH_SECURED
                          & EXT_MEM_ADDR_WIDTH_STRAP;
      end
      if (st_r.cnt == CNT_LAST) begin
        st_nxt.chip_rst = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + CW'(1);
      end
    end

    // software registers
    if (pin_low) begin
      st_nxt.pudr = PUDR_RST;
      st_nxt.pur  = PUR_RST;
      st_nxt.fsel = FSEL_RST;
      st_nxt.gdir = GDIR_RST;
      st_nxt.gout = GOUT_RST;
      st_nxt.icfg = ICFG_RST;
    end else if (wr_lo) begin
      case (rif.wr_addr)
        ADDR_PUDR: st_nxt.pudr = rif.wr_data[3:0];
        ADDR_PUR:  st_nxt.pur  = rif.wr_data[NUM_TPINS-1:0];
        ADDR_FSEL: st_nxt.fsel = rif.wr_data[NUM_TPINS-1:0];
        ADDR_GDIR: st_nxt.gdir = rif.wr_data[NUM_TPINS-1:0];
        ADDR_GOUT: st_nxt.gout = rif.wr_data[NUM_TPINS-1:0];
        ADDR_ICFG: st_nxt.icfg = rif.wr_data[NUM_IRQ-1:0];
        ADDR_OMR: begin
          // boot mode bit a only moves the map when the flash was open at reset
          if (st_r.mb && !st_r.chip_rst) begin
            st_nxt.ma = rif.wr_data[OMR_MA_BIT];
          end
        end
        default: st_nxt.pudr = st_r.pudr;
      endcase
    end

    // pin mux: pins are left undriven from the cycle after internal reset rises to the cycle after it drops, whichever function its select bit picks
    st_nxt.gin = TIMER_D_CHANNEL_PIN_I;
    st_nxt.tin = TIMER_D_CHANNEL_PIN_I;
    for (int k = 0; k < NUM_TPINS; k++) begin
      if (st_r.fsel[k]) begin
        st_nxt.pin_o[k]  = st_r.gout[k];
        st_nxt.pin_oe[k] = st_r.gdir[k] & ~st_r.chip_rst;
      end else begin
        st_nxt.pin_o[k]  = TIMER_OUT[k];
        st_nxt.pin_oe[k] = TIMER_OUT_EN[k] & ~st_r.chip_rst;
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      // power-on reset starts the release count from zero
      st_r          <= '0;
      st_r.chip_rst <= 1'b1;
      st_r.pur      <= PUR_RST;
      st_r.fsel     <= FSEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // register read and error decode
  // ----------------------------------------------------------------
  assign rif.wr_err = ~addr_known(rif.wr_addr);

  always_comb begin
    rif.rd_data = '0;
    rif.rd_err  = rif.rd_en & ~addr_known(rif.rd_addr);
    case (rif.rd_addr)
      ADDR_PUDR:  rif.rd_data[3:0]           = st_r.pudr;
      ADDR_PUR:   rif.rd_data[NUM_TPINS-1:0] = st_r.pur;
      ADDR_FSEL:  rif.rd_data[NUM_TPINS-1:0] = st_r.fsel;
      ADDR_GDIR:  rif.rd_data[NUM_TPINS-1:0] = st_r.gdir;
      ADDR_GOUT:  rif.rd_data[NUM_TPINS-1:0] = st_r.gout;
      ADDR_GIN:   rif.rd_data[NUM_TPINS-1:0] = st_r.gin;
      ADDR_ICFG:  rif.rd_data[NUM_IRQ-1:0]   = st_r.icfg;
      ADDR_ISTAT: begin
        rif.rd_data[NUM_IRQ-1:0]                         = irq_req & st_r.icfg;
        rif.rd_data[ISTAT_LVL_POS +: NUM_IRQ]            = irq_lvl;
      end
      ADDR_OMR: begin
        rif.rd_data[OMR_MA_BIT]  = st_r.ma;
        rif.rd_data[OMR_MB_BIT]  = st_r.mb;
        rif.rd_data[OMR_A20_BIT] = st_r.a20;
        rif.rd_data[OMR_RDY_BIT] = ~st_r.chip_rst;
      end
      default: rif.rd_data = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign CHIP_RESET             = st_r.chip_rst;
  assign RESET_STATUS_OUT       = st_r.chip_rst;
  assign BOOT_MODE_BIT_A        = st_r.ma;
  assign FLASH_SECURED_MODE_BIT = st_r.mb;
  assign EXTRA_ADDR_LINES_EN    = st_r.a20;
  assign RESET_PIN_PULLUP_EN    = ~st_r.pudr[PUD_RESET_BIT];
  assign IRQ_PINS_PULLUP_EN     = ~st_r.pudr[PUD_IRQ_BIT];
  assign BOOT_STRAP_PULLUP_EN   = ~st_r.pudr[PUD_BOOT_STRAP_PULLUP_DISABLE_BIT];
  assign WIDTH_STRAP_PULLUP_EN  = ~st_r.pudr[PUD_EMI_BIT];
  assign TIMER_PIN_PULLUP_EN    = st_r.pur;
  assign TIMER_D_CHANNEL_PIN_O  = st_r.pin_o;
  assign TIMER_D_CHANNEL_PIN_OE = st_r.pin_oe;
  assign TIMER_IN               = st_r.tin;

endmodule : rbic_ctrl

/* File: verif/rbic_ctrl_assertions.sv */
// pin-level checker for the reset, boot strap and interrupt control block
`timescale 1ns/1ps
module rbic_ctrl_assertions
  import rbic_pkg::*;
#(parameter int RELEASE_CYCLES = RESET_RELEASE_CYCLES) (
  input wire logic CLOCK, RST, EXT_RESET_PIN_N, EXTERNAL_BOOT_STRAP, EXT_MEM_ADDR_WIDTH_STRAP, FLASH_SECURED,
  input wire logic CHIP_RESET, RESET_STATUS_OUT, BOOT_MODE_BIT_A, FLASH_SECURED_MODE_BIT, EXTRA_ADDR_LINES_EN,
  input wire logic RESET_PIN_PULLUP_EN, IRQ_PINS_PULLUP_EN, BOOT_STRAP_PULLUP_EN, WIDTH_STRAP_PULLUP_EN,
  input wire logic LOW_POWER_MODE, EXT_INTERRUPT_REQ_A_N, EXT_INTERRUPT_REQ_B_N, WAKE_REQUEST, IRQ_SERVICE_A,
  input wire logic [NUM_TPINS-1:0] TIMER_PIN_PULLUP_EN, TIMER_D_CHANNEL_PIN_O, TIMER_D_CHANNEL_PIN_OE,
  input wire logic [NUM_TPINS-1:0] TIMER_OUT, TIMER_OUT_EN
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // edges since release with the pin high; saturates so it never wraps
  int cnt_r;
  always_ff @(posedge CLOCK or posedge RST)
    if (RST) cnt_r <= 0;
    else if (!EXT_RESET_PIN_N) cnt_r <= 0;
    else if (cnt_r < RELEASE_CYCLES) cnt_r <= cnt_r + 1;
  sequence s_a_fall; !CHIP_RESET && EXT_INTERRUPT_REQ_A_N ##1 !EXT_INTERRUPT_REQ_A_N [*5]; endsequence
  property p_status; RESET_STATUS_OUT == (cnt_r < RELEASE_CYCLES); endproperty
  property p_pin_hold; !EXT_RESET_PIN_N |=> CHIP_RESET [*2]; endproperty
  property p_release; CHIP_RESET == (cnt_r < RELEASE_CYCLES); endproperty
  property p_mode; cnt_r == 1 |-> BOOT_MODE_BIT_A == ($past(EXTERNAL_BOOT_STRAP) && !$past(FLASH_SECURED))
    && FLASH_SECURED_MODE_BIT == !$past(FLASH_SECURED); endproperty
  property p_width; cnt_r == 1 |-> EXTRA_ADDR_LINES_EN == ($past(EXT_MEM_ADDR_WIDTH_STRAP)
    && $past(EXTERNAL_BOOT_STRAP) && !$past(FLASH_SECURED)); endproperty
  property p_pull_dflt; !EXT_RESET_PIN_N |=> TIMER_PIN_PULLUP_EN == 4'hf && RESET_PIN_PULLUP_EN
    && IRQ_PINS_PULLUP_EN && BOOT_STRAP_PULLUP_EN && WIDTH_STRAP_PULLUP_EN; endproperty
  property p_wake;
    WAKE_REQUEST == (LOW_POWER_MODE && !(EXT_INTERRUPT_REQ_A_N && EXT_INTERRUPT_REQ_B_N)); endproperty
  property p_irq_answer; s_a_fall |-> IRQ_SERVICE_A; endproperty
  property p_irq_sync; $rose(IRQ_SERVICE_A) |-> !$past(EXT_INTERRUPT_REQ_A_N, 3); endproperty
  property p_timer_dflt; $fell(CHIP_RESET) |=> TIMER_D_CHANNEL_PIN_OE == $past(TIMER_OUT_EN)
    && TIMER_D_CHANNEL_PIN_O == $past(TIMER_OUT); endproperty
  a_status: assert property (p_status) else $error("status differs");
  a_pin_hold: assert property (p_pin_hold) else $error("reset not held");
  a_release: assert property (p_release) else $error("release count wrong");
  a_mode: assert property (p_mode) else $error("mode bits wrong");
  a_width: assert property (p_width) else $error("address width wrong");
  a_pull_dflt: assert property (p_pull_dflt) else $error("pull-ups off");
  a_wake: assert property (p_wake) else $error("wake wrong");
  a_irq_answer: assert property (p_irq_answer) else $error("no service");
  a_irq_sync: assert property (p_irq_sync) else $error("service too early");
  a_timer_dflt: assert property (p_timer_dflt) else $error("pins not timer");
endmodule : rbic_ctrl_assertions
bind rbic_ctrl rbic_ctrl_assertions #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_rbic_chk (.*);

/* File: verif/rbic_board.sv */
// board side model: reset circuit, boot straps and interrupting devices
`timescale 1ns/1ps
module rbic_board (
  input  wire logic clk, rst_req, boot, width, secured, irq_a, irq_b, slow,
  output logic      rst_pin_n, boot_pin, width_pin, sec_pin, irq_a_n, irq_b_n
);
  logic a_d, b_d;
  initial {rst_pin_n, boot_pin, width_pin, sec_pin, irq_a_n, irq_b_n, a_d, b_d} = 8'hfc;
  always @(posedge clk) begin
    rst_pin_n <= ~rst_req;  // device reset only, no test reset here
    if (rst_req) {boot_pin, width_pin, sec_pin} <= {boot, width, secured};
    {a_d, b_d} <= {irq_a, irq_b};
    // slow devices take one more cycle to pull the line down
    irq_a_n <= ~(slow ? a_d : irq_a);
    irq_b_n <= ~(slow ? b_d : irq_b);
  end
endmodule : rbic_board

/* File: verif/rbic_ctrl_test.sv */
// self-checking bench for the reset, boot strap and interrupt control block
`timescale 1ns/1ps
module rbic_ctrl_test;
  import rbic_pkg::*;
  logic CLOCK = 1'b0, RST = 1'b1;
  logic [RBIC_AW-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [RBIC_DW-1:0] S_AXI_WDATA, S_AXI_RDATA, q, m;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic [3:0] S_AXI_WSTRB = 4'hf;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, r;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, EXT_RESET_PIN_N, EXTERNAL_BOOT_STRAP;
  logic EXT_MEM_ADDR_WIDTH_STRAP, FLASH_SECURED, CHIP_RESET, RESET_STATUS_OUT, BOOT_MODE_BIT_A;
  logic FLASH_SECURED_MODE_BIT, EXTRA_ADDR_LINES_EN, RESET_PIN_PULLUP_EN, IRQ_PINS_PULLUP_EN;
  logic BOOT_STRAP_PULLUP_EN, WIDTH_STRAP_PULLUP_EN, LOW_POWER_MODE, WAKE_REQUEST, IRQ_SERVICE_A, IRQ_SERVICE_B;
  logic EXT_INTERRUPT_REQ_A_N, EXT_INTERRUPT_REQ_B_N, rq = 1'b0, bt, wd, sc, ia = 1'b0, ib = 1'b0, sl = 1'b0;
  logic [NUM_TPINS-1:0] TIMER_PIN_PULLUP_EN, TIMER_D_CHANNEL_PIN_I, TIMER_D_CHANNEL_PIN_O, TIMER_D_CHANNEL_PIN_OE;
  logic [NUM_TPINS-1:0] TIMER_OUT, TIMER_OUT_EN, TIMER_IN, pto, pte, pti;
  int miscompares = 0, total_checks = 0, seed = 54946, i, n;
  rbic_ctrl #(.RELEASE_CYCLES(4)) i_rbic_ctrl (.*);
  rbic_board i_rbic_board (.clk(CLOCK), .rst_req(rq), .boot(bt), .width(wd), .secured(sc), .irq_a(ia),
    .irq_b(ib), .slow(sl), .rst_pin_n(EXT_RESET_PIN_N), .boot_pin(EXTERNAL_BOOT_STRAP),
    .width_pin(EXT_MEM_ADDR_WIDTH_STRAP), .sec_pin(FLASH_SECURED), .irq_a_n(EXT_INTERRUPT_REQ_A_N),
    .irq_b_n(EXT_INTERRUPT_REQ_B_N));
  always #2 CLOCK = ~CLOCK;
  // p* keep what the last edge sampled
  always @(posedge CLOCK) begin
    {pto, pte, pti} <= {TIMER_OUT, TIMER_OUT_EN, TIMER_D_CHANNEL_PIN_I};
    {TIMER_OUT, TIMER_OUT_EN, TIMER_D_CHANNEL_PIN_I} <= 12'($random(seed));
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input logic ok);
    if (!ok) begin
      miscompares++;
      final_report();
    end
  endtask : tmo
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    if (w) {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= {a, d, 3'h7};
    else {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'h3};
    for (n = 0; n < 64; n++) begin
      @(posedge CLOCK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (w ? S_AXI_BVALID : S_AXI_RVALID) break;
    end
    {S_AXI_BREADY, S_AXI_RREADY} <= 2'h0;
    {q, r} = {S_AXI_RDATA, w ? S_AXI_BRESP : S_AXI_RRESP};
    tmo(n < 64);
  endtask : bus
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RBIC_RESP_OKAY);
    bus(1'b1, a, d);
    chk(r, er);
  endtask : wreg
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RBIC_RESP_OKAY);
    bus(1'b0, a, 32'h0);
    chk({r, q}, {er, e});
  endtask : rreg
  initial begin
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, LOW_POWER_MODE} = 6'h0;
    {TIMER_OUT, TIMER_OUT_EN, TIMER_D_CHANNEL_PIN_I, bt, wd, sc} = 15'h7;
    repeat (3) @(posedge CLOCK);
    RST <= 1'b0;
    rreg(ADDR_PUDR, 32'(PUDR_RST));
    rreg(ADDR_PUR, 32'(PUR_RST));
    rreg(ADDR_FSEL, 32'(FSEL_RST));
    rreg(ADDR_ICFG, 32'(ICFG_RST));
    rreg(8'h40, 32'h0, RBIC_RESP_SLVERR);
    wreg(8'h44, 32'h1, RBIC_RESP_SLVERR);
    $display("test done: defaults");
    for (i = 0; i < 8; i++) begin
      {bt, wd, sc, rq} <= {3'(i), 1'b1};
      repeat (3) @(posedge CLOCK);
      rq <= 1'b0;
      for (n = 0; n < 20 && CHIP_RESET !== 1'b0; n++) @(posedge CLOCK);
      tmo(n < 20);
      #1 chk({BOOT_MODE_BIT_A, FLASH_SECURED_MODE_BIT, EXTRA_ADDR_LINES_EN}, {bt & ~sc, ~sc, wd & bt & ~sc});
      rreg(ADDR_OMR, {28'h0, 1'b1, wd & bt & ~sc, ~sc, bt & ~sc});
      wreg(ADDR_OMR, 32'h1);
      rreg(ADDR_OMR, {28'h1, wd & bt & ~sc, ~sc, ~sc});
    end
    $display("test done: straps");
    for (i = 0; i < 4; i++) begin
      m = $random(seed);
      wreg(ADDR_PUDR, {28'h0, m[3:0]});
      wreg(ADDR_PUR, {28'h0, m[7:4]});
      #1 chk({WIDTH_STRAP_PULLUP_EN, BOOT_STRAP_PULLUP_EN, IRQ_PINS_PULLUP_EN, RESET_PIN_PULLUP_EN}, 4'(~m[3:0]));
      chk(TIMER_PIN_PULLUP_EN, m[7:4]);
    end
    $display("test done: pull-ups");
    for (i = 0; i < 6; i++) begin
      m = $random(seed);
      wreg(ADDR_FSEL, {28'h0, m[3:0]});
      wreg(ADDR_GDIR, {28'h0, m[7:4]});
      wreg(ADDR_GOUT, {28'h0, m[11:8]});
      @(posedge CLOCK);
      #1 chk({TIMER_D_CHANNEL_PIN_OE, TIMER_D_CHANNEL_PIN_O, TIMER_IN},
        {m[3:0] & m[7:4] | ~m[3:0] & pte, m[3:0] & m[11:8] | ~m[3:0] & pto, pti});
    end
    $display("test done: timer pins");
    for (i = 0; i < 2; i++) begin
      wreg(ADDR_ICFG, {30'h0, i[0], i[0]});
      {ia, ib, sl, LOW_POWER_MODE} <= {2'h3, i[0], i[0]};
      repeat (7) @(posedge CLOCK);
      #1 chk({IRQ_SERVICE_B, IRQ_SERVICE_A, WAKE_REQUEST}, {2'h3, i[0]});
      rreg(ADDR_ISTAT, {28'h3, i[0], i[0]});
      {ia, ib} <= 2'h0;
      repeat (7) @(posedge CLOCK);
      #1 chk({IRQ_SERVICE_B, IRQ_SERVICE_A, WAKE_REQUEST}, {i[0], i[0], 1'b0});
      wreg(ADDR_ISTAT, 32'h3);
      rreg(ADDR_ISTAT, 32'h0);
    end
    $display("test done: interrupts");
    final_report();
  end
endmodule : rbic_ctrl_test
